/* File: hdl/sspc_map.vh */
// Purpose: constants for the switcher sequence, phase and pin configuration
// Assumes: byte-wide command codes from the host command front end
// Notes:   offsets are the command codes of the host protocol
`ifndef SSPC_MAP_VH
`define SSPC_MAP_VH

// ****************************************
// command codes
// ****************************************
`define SSPC_CMD_PIN_FUNC     8'hD3
`define SSPC_CMD_PG_CHECK     8'hD4
`define SSPC_CMD_SEQ_POS      8'hD5
`define SSPC_CMD_COND_MODE    8'hD6
`define SSPC_CMD_FREQ_PHASE   8'hD7

// ****************************************
// field positions and widths
// ****************************************
`define SSPC_ROLE_BIT         0
`define SSPC_PGCHK_BIT        0
`define SSPC_START_LSB        0
`define SSPC_STOP_LSB         2
`define SSPC_CCM_BIT          0
`define SSPC_SHARE_BIT        1
`define SSPC_DIV_LSB          0
`define SSPC_PHASE_LSB        2
`define SSPC_FP_W             7

// ****************************************
// reset values
// ****************************************
`define SSPC_RST_ROLE         1'h0
`define SSPC_RST_PGCHK        1'h0
`define SSPC_RST_SEQ_POS      4'h0
`define SSPC_RST_CCM          1'h1
`define SSPC_RST_DIV          2'h0
`define SSPC_RST_PH0          5'h00
`define SSPC_RST_PH1          5'h02
`define SSPC_RST_PH2          5'h01
`define SSPC_RST_PH3          5'h03

// ****************************************
// timing: pll periods per oscillator period
// ****************************************
`define SSPC_PLL_PER_OSC      6'h04
`define SSPC_HALF_TURN        6'h02
`define SSPC_LAST_PAGE        2'h3

`endif

/* File: hdl/sspc_phase_tick.v */
// Purpose: one switcher's pwm sync pulse from divisor and phase delay
// Assumes: base_cnt counts pll periods, wraps at 32, shared by all outputs
// Notes:   sync pulse is registered
`timescale 1ns/1ps
`include "sspc_map.vh"

module sspc_phase_tick (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // timing base
  input  wire       pll_tick,
  input  wire [4:0] base_cnt,
  // settings in force
  input  wire [1:0] clk_div,
  input  wire [4:0] phase_dly,
  // pwm start pulse
  output reg        pwm_sync
);

  // ****************************************
  // switching period is 4 << div pll periods
  // ****************************************
  wire [5:0] period_len;
  wire [5:0] period_m1;
  wire [4:0] period_mask;
  wire [4:0] in_period;
  wire [4:0] eff_phase;

  assign period_len  = `SSPC_PLL_PER_OSC << clk_div;
  assign period_m1   = period_len - 6'h01;
  assign period_mask = period_m1[4:0];
  assign in_period   = base_cnt & period_mask;
  // a delay past the period wraps into it rather than never firing
  assign eff_phase   = phase_dly & period_mask;

  always @(posedge clk) begin
    if (rst) begin
      pwm_sync <= 1'b0;
    end else begin
      pwm_sync <= pll_tick && (in_period == eff_phase);
    end
  end

endmodule // sspc_phase_tick

/* File: hdl/sspc_seq_cfg.v */
// Purpose: per-output pin role, sequencing, conduction mode and pwm phase
// Assumes: host front end delivers decoded command writes and reads
// Notes:   nvm store and reload are modelled by two pulses
`timescale 1ns/1ps
`include "sspc_map.vh"

module sspc_seq_cfg (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // host command port
  input  wire [1:0]  page_sel,
  input  wire [7:0]  cmd_code,
  input  wire        cmd_wr,
  input  wire [7:0]  cmd_wdata,
  input  wire        cmd_rd,
  output reg  [7:0]  cmd_rdata,
  output reg         cmd_rvalid,
  output reg         cmd_hit,
  // nvm image control
  input  wire        nvm_store,
  input  wire        nvm_reload,
  // sequencing
  input  wire        seq_start,
  input  wire        seq_stop,
  input  wire [3:0]  pgood,
  output wire [3:0]  sw_enable,
  output wire        seq_busy,
  // shared soft-start / power-good pins
  output wire [3:0]  sspg_out,
  output wire [3:0]  sspg_oe,
  output wire [3:0]  softstart_cap_input,
  output wire [3:0]  int_ramp_en,
  // current sharing
  input  wire [1:0]  share_detect,
  output wire [1:0]  share_indication,
  // switcher control
  input  wire        pll_tick,
  output wire [3:0]  ccm_en,
  output wire [3:0]  pwm_sync,
  output wire [7:0]  clk_div_all
);

  // ****************************************
  // decode helpers
  // ****************************************
  function is_slave;
    input [1:0] pg;
    begin
      is_slave = pg[0];
    end
  endfunction

  function [1:0] master_of;
    input [1:0] pg;
    begin
      master_of = {pg[1], 1'b0};
    end
  endfunction

  // 180 degrees later: half of the 4 << div pll periods of one cycle
  function [4:0] half_turn;
    input [4:0] ph;
    input [1:0] dv;
    reg   [5:0] sum;
    reg   [5:0] len;
    begin
      len       = `SSPC_PLL_PER_OSC << dv;
      sum       = {1'b0, ph} + (`SSPC_HALF_TURN << dv);
      sum       = sum & (len - 6'h01);
      half_turn = sum[4:0];
    end
  endfunction

  function [4:0] rst_phase;
    input [1:0] pg;
    begin
      case (pg)
        2'h0:    rst_phase = `SSPC_RST_PH0;
        2'h1:    rst_phase = `SSPC_RST_PH1;
        2'h2:    rst_phase = `SSPC_RST_PH2;
        default: rst_phase = `SSPC_RST_PH3;
      endcase
    end
  endfunction

  // ****************************************
  // storage: staged, nvm image, in force
  // ****************************************
  reg  [3:0]  stg_role_ff;
  reg  [3:0]  nvm_role_ff;
  reg  [3:0]  act_role_ff;
  reg  [3:0]  stg_ccm_ff;
  reg  [3:0]  nvm_ccm_ff;
  reg  [3:0]  act_ccm_ff;
  reg  [6:0]  stg_fp_ff [0:3];
  reg  [6:0]  nvm_fp_ff [0:3];
  reg  [6:0]  act_fp_ff [0:3];
  reg  [3:0]  seq_pos_ff [0:3];
  reg         pg_skip_ff;

  wire        slave_bad;
  wire        wr_ok;

  // a per-page write to a sharing slave page is dropped: that page is invalid
  assign slave_bad = is_slave(page_sel) && share_detect[page_sel[1]];
  assign wr_ok     = cmd_wr && !slave_bad;

  integer i, j;

  always @(posedge clk) begin
    if (rst) begin
      pg_skip_ff <= `SSPC_RST_PGCHK;
      for (i = 0; i < 4; i = i + 1) begin
        seq_pos_ff[i] <= `SSPC_RST_SEQ_POS;
      end
    end else begin
      if (cmd_wr && cmd_code == `SSPC_CMD_PG_CHECK) begin
        pg_skip_ff <= cmd_wdata[`SSPC_PGCHK_BIT];
      end
      if (wr_ok && cmd_code == `SSPC_CMD_SEQ_POS) begin
        seq_pos_ff[page_sel] <= cmd_wdata[3:0];
      end
    end
  end

  // live writes only land in the staged copy; the core keeps running
  // on the copy taken at the last reload
  always @(posedge clk) begin
    if (rst) begin
      stg_role_ff <= {4{`SSPC_RST_ROLE}};
      nvm_role_ff <= {4{`SSPC_RST_ROLE}};
      act_role_ff <= {4{`SSPC_RST_ROLE}};
      stg_ccm_ff  <= {4{`SSPC_RST_CCM}};
      nvm_ccm_ff  <= {4{`SSPC_RST_CCM}};
      act_ccm_ff  <= {4{`SSPC_RST_CCM}};
      for (j = 0; j < 4; j = j + 1) begin
        stg_fp_ff[j] <= {rst_phase(j[1:0]), `SSPC_RST_DIV};
        nvm_fp_ff[j] <= {rst_phase(j[1:0]), `SSPC_RST_DIV};
        act_fp_ff[j] <= {rst_phase(j[1:0]), `SSPC_RST_DIV};
      end
    end else begin
      if (wr_ok && cmd_code == `SSPC_CMD_PIN_FUNC) begin
        stg_role_ff[page_sel] <= cmd_wdata[`SSPC_ROLE_BIT];
      end
      if (wr_ok && cmd_code == `SSPC_CMD_COND_MODE) begin
        stg_ccm_ff[page_sel] <= cmd_wdata[`SSPC_CCM_BIT];
      end
      if (wr_ok && cmd_code == `SSPC_CMD_FREQ_PHASE) begin
        stg_fp_ff[page_sel] <= cmd_wdata[6:0];
      end
      if (nvm_store) begin
        nvm_role_ff <= stg_role_ff;
        nvm_ccm_ff  <= stg_ccm_ff;
        for (j = 0; j < 4; j = j + 1) begin
          nvm_fp_ff[j] <= stg_fp_ff[j];
        end
      end
      if (nvm_reload) begin
        act_role_ff <= nvm_role_ff;
        act_ccm_ff  <= nvm_ccm_ff;
        stg_role_ff <= nvm_role_ff;
        stg_ccm_ff  <= nvm_ccm_ff;
        for (j = 0; j < 4; j = j + 1) begin
          act_fp_ff[j] <= nvm_fp_ff[j];
          stg_fp_ff[j] <= nvm_fp_ff[j];
        end
      end
    end
  end

  // ****************************************
  // read back
  // ****************************************
  reg [7:0] nxt_rdata;
  reg       nxt_hit;

  always @* begin
    nxt_rdata = 8'h00;
    nxt_hit   = 1'b1;
    case (cmd_code)
      `SSPC_CMD_PIN_FUNC:
        nxt_rdata = {7'h00, stg_role_ff[page_sel]};
      `SSPC_CMD_PG_CHECK:
        nxt_rdata = {7'h00, pg_skip_ff};
      `SSPC_CMD_SEQ_POS:
        nxt_rdata = {4'h0, seq_pos_ff[page_sel]};
      `SSPC_CMD_COND_MODE: begin
        nxt_rdata[`SSPC_CCM_BIT] = stg_ccm_ff[page_sel];
        if (!is_slave(page_sel)) begin
          nxt_rdata[`SSPC_SHARE_BIT] = share_detect[page_sel[1]];
        end
      end
      `SSPC_CMD_FREQ_PHASE:
        nxt_rdata = {1'b0, stg_fp_ff[page_sel]};
      default:
        nxt_hit = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      cmd_rdata  <= 8'h00;
      cmd_rvalid <= 1'b0;
      cmd_hit    <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        cmd_rdata <= nxt_rdata;
        cmd_hit   <= nxt_hit;
      end
    end
  end

  // ****************************************
  // settings in force, with pair sharing
  // ****************************************
  wire [3:0] eff_ccm;
  wire [1:0] eff_div [0:3];
  wire [4:0] eff_ph  [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_eff
      localparam integer MP = g - (g % 2);
      wire sh = (g % 2 == 1) && share_detect[g / 2];
      // slave follows master, except its phase is half a cycle later
      assign eff_ccm[g] = sh ? act_ccm_ff[MP] : act_ccm_ff[g];
      assign eff_div[g] = sh ? act_fp_ff[MP][1:0] : act_fp_ff[g][1:0];
      assign eff_ph[g]  = sh ? half_turn(act_fp_ff[MP][6:2],
                                         act_fp_ff[MP][1:0])
                             : act_fp_ff[g][6:2];
      assign clk_div_all[2*g+1:2*g] = eff_div[g];
    end
  endgenerate

  assign ccm_en           = eff_ccm;
  assign share_indication = share_detect;

  // ****************************************
  // pwm phase timing
  // ****************************************
  reg [4:0] base_cnt_ff;

  always @(posedge clk) begin
    if (rst) begin
      base_cnt_ff <= 5'h00;
    end else if (pll_tick) begin
      base_cnt_ff <= base_cnt_ff + 5'h01;
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pwm
      sspc_phase_tick u_tick (
        .clk       (clk),
        .rst       (rst),
        .pll_tick  (pll_tick),
        .base_cnt  (base_cnt_ff),
        .clk_div   (eff_div[g]),
        .phase_dly (eff_ph[g]),
        .pwm_sync  (pwm_sync[g])
      );
    end
  endgenerate

  // ****************************************
  // shared soft-start / power-good pins
  // ****************************************
  assign softstart_cap_input = ~act_role_ff;
  assign int_ramp_en         = act_role_ff;
  assign sspg_oe             = act_role_ff;
  assign sspg_out            = ~pgood;

  // ****************************************
  // start / stop sequencer
  // ****************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_STOP  = 2'h2;

  reg  [1:0] state_ff;
  reg  [1:0] step_ff;
  reg  [3:0] en_ff;
  reg  [1:0] nxt_state;
  reg  [1:0] nxt_step;
  reg  [3:0] nxt_en;
  wire [3:0] start_grp;
  wire [3:0] stop_grp;
  wire       grp_good;

  // order is read live: a rewrite mid-sequence moves outputs between steps
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_grp
      assign start_grp[g] = (seq_pos_ff[g][1:0] == step_ff);
      assign stop_grp[g]  = (seq_pos_ff[g][3:2] == step_ff);
    end
  endgenerate

  assign grp_good = &(pgood | ~start_grp);

  always @* begin
    nxt_state = state_ff;
    nxt_step  = step_ff;
    nxt_en    = en_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_step = 2'h0;
        if (seq_stop) begin
          nxt_state = ST_STOP;
        end else if (seq_start) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        // step 0 turns on at once; later steps only after the gate
        nxt_en = en_ff | start_grp;
        if (seq_stop) begin
          nxt_state = ST_STOP;
          nxt_step  = 2'h0;
        end else if (pg_skip_ff || grp_good) begin
          if (step_ff == `SSPC_LAST_PAGE) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_step = step_ff + 2'h1;
          end
        end
      end
      ST_STOP: begin
        nxt_en = en_ff & ~stop_grp;
        if (step_ff == `SSPC_LAST_PAGE) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_step = step_ff + 2'h1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_step  = 2'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      step_ff  <= 2'h0;
      en_ff    <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      step_ff  <= nxt_step;
      en_ff    <= nxt_en;
    end
  end

  assign sw_enable = en_ff;
  assign seq_busy  = (state_ff != ST_IDLE);

endmodule // sspc_seq_cfg

/* File: dv/sspc_props.sv */
// Purpose: port checker for the sequence and phase configuration block
// Assumes: one clock, synchronous active high reset
// Notes:   bound to sspc_seq_cfg from the bench top file
`timescale 1ns/1ps
module sspc_props (
  // clock and reset
  input wire       clk,
  input wire       rst,
  // host port
  input wire [1:0] page_sel,
  input wire [7:0] cmd_code,
  input wire       cmd_rd,
  input wire [7:0] cmd_rdata,
  input wire       cmd_rvalid,
  input wire       cmd_hit,
  input wire       nvm_reload,
  // sequencer
  input wire       seq_start,
  input wire       seq_stop,
  input wire [3:0] pgood,
  input wire [3:0] sw_enable,
  input wire       seq_busy,
  // pins and switchers
  input wire [3:0] sspg_out,
  input wire [3:0] sspg_oe,
  input wire [3:0] softstart_cap_input,
  input wire [3:0] int_ramp_en,
  input wire [1:0] share_detect,
  input wire [1:0] share_indication,
  input wire       pll_tick,
  input wire [3:0] ccm_en,
  input wire [3:0] pwm_sync,
  input wire [7:0] clk_div_all
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // slaves follow sharing in the same cycle; still require it settled twice
  reg  [1:0] sd_ff;
  wire       unk = cmd_code < 8'hD3 || cmd_code > 8'hD7;
  always @(posedge clk) sd_ff <= share_detect;
  sequence s_stop_run;
    seq_busy [*3];
  endsequence
  sequence s_off;
    !seq_busy && sw_enable == 4'h0;
  endsequence
  a_rd_answer: assert property (cmd_rd |=> cmd_rvalid)
    else $error("read not answered");
  a_rd_unknown: assert property (cmd_rd && unk |=> !cmd_hit && cmd_rdata == 8'h00)
    else $error("unknown code read wrong");
  a_slave_share: assert property (cmd_rd && cmd_code == 8'hD6 && page_sel[0] |=> !cmd_rdata[1])
    else $error("share bit seen on slave page");
  a_pg_drive: assert property (sspg_out == ~pgood)
    else $error("power-good pin level wrong");
  a_role_pins: assert property (sspg_oe == ~softstart_cap_input && int_ramp_en == sspg_oe)
    else $error("pin role outputs disagree");
  a_share_flag: assert property (share_indication == share_detect)
    else $error("share indication wrong");
  a_cfg_frozen: assert property (!$past(nvm_reload) && share_detect == sd_ff && sd_ff == $past(sd_ff) |-> $stable(sspg_oe) && $stable(ccm_en) && $stable(clk_div_all))
    else $error("setting changed without reload");
  a_start_busy: assert property (seq_start && !seq_busy && !seq_stop |=> seq_busy)
    else $error("start not taken");
  a_stop_seq: assert property (seq_stop |=> s_stop_run ##[1:4] s_off)
    else $error("stop sequence wrong");
  a_sync_tick: assert property (pwm_sync != 4'h0 |-> $past(pll_tick))
    else $error("sync pulse off tick");
endmodule // sspc_props

/* File: dv/sspc_host.sv */
// Purpose: host command model driving the configuration port
// Assumes: strobes taken on the rising edge, read answered a cycle later
// Notes:   data lines show the inverse value once released
`timescale 1ns/1ps
module sspc_host (
  // clock
  input  wire        clk,
  // command port
  output logic [1:0] page_sel,
  output logic [7:0] cmd_code,
  output logic       cmd_wr,
  output logic [7:0] cmd_wdata,
  output logic       cmd_rd,
  input  wire  [7:0] cmd_rdata,
  input  wire        cmd_rvalid,
  input  wire        cmd_hit
);
  initial begin
    page_sel = 2'h0;
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_wdata = 8'h00;
    cmd_rd = 1'b0;
  end
  task automatic wr(input logic [1:0] p, input logic [7:0] c, d);
    @(posedge clk);
    page_sel <= p;
    cmd_code <= c;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_wdata <= ~d;
  endtask
  task automatic rd(input logic [1:0] p, input logic [7:0] c,
                    output logic [7:0] d, output logic h);
    int n;
    @(posedge clk);
    page_sel <= p;
    cmd_code <= c;
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    // the answer stands one cycle only: look just after it is launched
    n = 0;
    #1;
    while (cmd_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = (cmd_rvalid === 1'b1) ? cmd_rdata : 8'hXX;
    h = (cmd_rvalid === 1'b1) ? cmd_hit : 1'bx;
  endtask
endmodule // sspc_host

/* File: dv/tb.sv */
// Purpose: self-checking bench for sspc_seq_cfg
// Assumes: pll tick every fourth clock
// Notes:   host writes order and check only while all outputs are off
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       nvm_store = 1'b0, nvm_reload = 1'b0, pll_tick = 1'b0;
  logic       seq_start = 1'b0, seq_stop = 1'b0;
  logic [3:0] pgood = 4'h0;
  logic [1:0] share_detect = 2'h0;
  wire  [1:0] page_sel, share_indication;
  wire  [7:0] cmd_code, cmd_wdata, cmd_rdata, clk_div_all;
  wire        cmd_wr, cmd_rd, cmd_rvalid, cmd_hit, seq_busy;
  wire  [3:0] sw_enable, sspg_out, sspg_oe, softstart_cap_input;
  wire  [3:0] int_ramp_en, ccm_en, pwm_sync;
  int         error_cnt = 0, check_count = 0, cyc = 0;
  logic [4:0] ph [4] = '{5'h00, 5'h02, 5'h01, 5'h03};
  logic [7:0] wv [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFF};
  logic [7:0] rv [5] = '{8'h01, 8'h01, 8'h0F, 8'h00, 8'h7F};
  always #4 clk = ~clk;
  sspc_host sspc_host_i (.clk, .page_sel, .cmd_code, .cmd_wr, .cmd_wdata,
    .cmd_rd, .cmd_rdata, .cmd_rvalid, .cmd_hit);
  sspc_seq_cfg sspc_seq_cfg_i (.clk, .rst, .page_sel, .cmd_code, .cmd_wr,
    .cmd_wdata, .cmd_rd, .cmd_rdata, .cmd_rvalid, .cmd_hit, .nvm_store,
    .nvm_reload, .seq_start, .seq_stop, .pgood, .sw_enable, .seq_busy,
    .sspg_out, .sspg_oe, .softstart_cap_input, .int_ramp_en,
    .share_detect, .share_indication, .pll_tick, .ccm_en, .pwm_sync,
    .clk_div_all);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pll_tick <= (cyc % 4 == 3);
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [1:0] p, input logic [7:0] c, e);
    logic [7:0] d;
    logic       h;
    sspc_host_i.rd(p, c, d, h);
    chk("read data", e, d);
    chk("read hit", {7'h00, c >= 8'hD3 && c <= 8'hD7}, {7'h00, h});
  endtask
  task automatic kick(input logic stop);
    @(posedge clk);
    seq_start <= !stop;
    seq_stop <= stop;
    @(posedge clk);
    seq_start <= 1'b0;
    seq_stop <= 1'b0;
  endtask
  task automatic wait_en(input logic [3:0] e);
    int n;
    n = 0;
    while (sw_enable !== e && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("sw_enable", {4'h0, e}, {4'h0, sw_enable});
  endtask
  task automatic gap(input int a, b, output int n);
    n = 0;
    while (pwm_sync[a] !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (pwm_sync[b] !== 1'b1 && n < 300);
  endtask
  task automatic t_defaults;
    for (int p = 0; p < 4; p++) begin
      rchk(p[1:0], 8'hD3, 8'h00);
      rchk(p[1:0], 8'hD5, 8'h00);
      rchk(p[1:0], 8'hD6, 8'h01);
      rchk(p[1:0], 8'hD7, {1'b0, ph[p], 2'h0});
    end
    rchk(2'h0, 8'hD4, 8'h00);
    rchk(2'h0, 8'hD8, 8'h00);
    $display("test defaults done");
  endtask
  task automatic t_reserved;
    int n;
    for (int i = 0; i < 5; i++) begin
      sspc_host_i.wr(2'h0, 8'hD3 + i, wv[i]);
      rchk(2'h0, 8'hD3 + i, rv[i]);
    end
    chk("role live", 8'h00, {4'h0, sspg_oe});
    chk("ccm live", 8'h0F, {4'h0, ccm_en});
    chk("div live", 8'h00, clk_div_all);
    @(posedge clk) nvm_store <= 1'b1;
    @(posedge clk) nvm_store <= 1'b0;
    nvm_reload <= 1'b1;
    @(posedge clk) nvm_reload <= 1'b0;
    @(posedge clk);
    chk("role", 8'h01, {4'h0, sspg_oe});
    chk("ramp", 8'h01, {4'h0, int_ramp_en});
    chk("ccm", 8'h0E, {4'h0, ccm_en});
    chk("div", 8'h03, clk_div_all);
    gap(0, 0, n);
    chk("period", 8'h80, n[7:0]);
    $display("test reserved and reload done");
  endtask
  task automatic t_seq;
    sspc_host_i.wr(2'h0, 8'hD4, 8'h00);
    sspc_host_i.wr(2'h0, 8'hD5, 8'h00);
    sspc_host_i.wr(2'h1, 8'hD5, 8'h01);
    sspc_host_i.wr(2'h2, 8'hD5, 8'h01);
    sspc_host_i.wr(2'h3, 8'hD5, 8'h03);
    rchk(2'h3, 8'hD5, 8'h03);
    kick(1'b0);
    wait_en(4'h1);
    repeat (10) @(posedge clk);
    chk("held", 8'h01, {4'h0, sw_enable});
    @(posedge clk) pgood <= 4'h1;
    wait_en(4'h7);
    @(posedge clk) pgood <= 4'h7;
    wait_en(4'hF);
    kick(1'b1);
    wait_en(4'h0);
    @(posedge clk) pgood <= 4'h0;
    sspc_host_i.wr(2'h2, 8'hD4, 8'h01);
    rchk(2'h0, 8'hD4, 8'h01);
    kick(1'b0);
    wait_en(4'hF);
    kick(1'b1);
    wait_en(4'h0);
    $display("test sequencing done");
  endtask
  task automatic t_share;
    int n;
    @(posedge clk) share_detect <= 2'h1;
    rchk(2'h0, 8'hD6, 8'h02);
    rchk(2'h1, 8'hD6, 8'h01);
    sspc_host_i.wr(2'h1, 8'hD5, 8'h02);
    chk("slave div", 8'h03, {6'h0, clk_div_all[3:2]});
    chk("slave ccm", 8'h00, {7'h0, ccm_en[1]});
    gap(0, 1, n);
    chk("slave lag", 8'h40, n[7:0]);
    @(posedge clk) share_detect <= 2'h0;
    rchk(2'h1, 8'hD5, 8'h01);
    $display("test sharing done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_reserved;
    t_seq;
    t_share;
    print_verdict;
  end
endmodule // tb
bind sspc_seq_cfg sspc_props sspc_props_i (.clk, .rst, .page_sel, .cmd_code,
  .cmd_rd, .cmd_rdata, .cmd_rvalid, .cmd_hit, .nvm_reload, .seq_start,
  .seq_stop, .pgood, .sw_enable, .seq_busy, .sspg_out, .sspg_oe,
  .softstart_cap_input, .int_ramp_en, .share_detect, .share_indication,
  .pll_tick, .ccm_en, .pwm_sync, .clk_div_all);
